/* include/ccps_pkg.sv */
// Constants, types and register map of the channel post and schedule block.
// Assumes one clock domain; included before every design file.
package ccps_pkg;
	localparam int NCH = 6;
	// ----------------------------------------
	// Register indices (byte address is four times)
	// ----------------------------------------
	localparam logic [7:0] IDX_FMT [0:5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	localparam logic [7:0] IDX_SCH [0:5] = '{8'h05, 8'h0A, 8'h0D, 8'h11, 8'h15, 8'h19};
	localparam logic [7:0] IDX_RATE = 8'h20;
	localparam logic [7:0] IDX_PM0 = 8'h21;
	localparam logic [7:0] IDX_LIM1 = 8'h24;
	localparam logic [7:0] IDX_LIM2 = 8'h25;
	localparam logic [7:0] IDX_LIML = 8'h26;
	localparam logic [7:0] IDX_STS = 8'h27;
	localparam logic [7:0] IDX_MSK = 8'h28;
	localparam logic [7:0] IDX_CTL = 8'h29;
	localparam logic [7:0] IDX_FORCE = 8'h2A;
	localparam logic [7:0] IDX_RES0 = 8'h30;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int FMT_WIDE_BIT = 6;
	localparam int FMT_SHIFT_LSB = 3;
	localparam int FMT_POL_BIT = 2;
	localparam int FMT_MODE_LSB = 0;
	localparam int SCH_CNT_LSB = 6;
	localparam int SCH_BANK_BIT = 3;
	localparam int SCH_EM2_BIT = 2;
	localparam int SCH_EM3_BIT = 1;
	localparam int SCH_EM1_BIT = 0;
	localparam int CTL_LEGACY_BIT = 0;
	// ----------------------------------------
	// Reset values, timing, responses
	// ----------------------------------------
	localparam logic [7:0] FMT_RST = 8'h00;
	localparam logic [7:0] SCH_RST = 8'h00;
	localparam int TICK_US = 800;
	localparam int CLK_MHZ = 125;
	localparam int TICK_CYC = TICK_US * CLK_MHZ;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {CMP_EVERY, CMP_LIM_A, CMP_LIM_B, CMP_WINDOW} ccps_cmp_e;
	typedef struct packed {
		logic [2:0] chan;
		logic [23:0] acc;
	} ccps_sample_s;
	typedef struct packed {
		logic on_one;
		logic on_two;
		logic on_three;
		logic bank;
	} ccps_drive_s;
	typedef struct packed {
		logic valid;
		logic [2:0] chan;
		logic [23:0] result;
		logic hit;
	} ccps_post_s;
	typedef struct packed {
		logic [5:0][7:0] fmt;
		logic [5:0][7:0] sch;
		logic [15:0] rate;
		logic [2:0][7:0] pm;
		logic [23:0] lim1;
		logic [23:0] lim2;
		logic [23:0] liml;
		logic legacy;
		logic [5:0] sts;
		logic [5:0] msk;
		logic irq;
		logic [5:0][23:0] res;
		logic [16:0] tick;
		logic [5:0][23:0] cnt;
		logic [5:0] req;
		logic [5:0] force_req;
		ccps_drive_s drive;
		logic awrdy;
		logic wrdy;
		logic have_aw;
		logic have_w;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} ccps_top_s;
endpackage

/* verilog/ccps_post.sv */
// Shift, width formatting and threshold compare of one finished sample.
// Assumes configuration and limits come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ccps_post (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_valid,
	input wire logic [2:0] i_chan,
	input wire logic [23:0] i_acc,
	input wire logic [7:0] i_fmt,
	input wire logic [23:0] i_first,
	input wire logic [23:0] i_second,
	input wire logic [23:0] i_low,
	input wire logic i_legacy,
	output logic o_valid,
	output logic [2:0] o_chan,
	output logic [23:0] o_result,
	output logic o_hit
);
	ccps_pkg::ccps_post_s st_reg, st_next;
	logic wide, pol, gt1, lt1, gt2, outw, hit;
	logic [2:0] sh;
	ccps_pkg::ccps_cmp_e mode;
	logic [23:0] shd, res;
	logic signed [24:0] sv, l1, l2, ll;

	// Limits follow the sample format
	function automatic logic signed [24:0] lim(input logic [23:0] x, input logic w);
		lim = w ? {x[23], x} : {9'h000, x[15:0]};
	endfunction

	// Format the sum, then compare the final value
	always_comb begin
		wide = i_fmt[ccps_pkg::FMT_WIDE_BIT];
		sh = i_fmt[ccps_pkg::FMT_SHIFT_LSB +: 3];
		pol = i_fmt[ccps_pkg::FMT_POL_BIT];
		mode = ccps_pkg::ccps_cmp_e'(i_fmt[ccps_pkg::FMT_MODE_LSB +: 2]);
		shd = 24'($signed(i_acc) >>> sh);
		res = wide ? shd : {8'h00, shd[15:0]};
		sv = wide ? {res[23], res} : {1'b0, res};
		l1 = lim(i_first, wide);
		l2 = lim(i_second, wide);
		ll = lim(i_low, wide);
		gt1 = sv > l1;
		lt1 = sv < l1;
		gt2 = sv > l2;
		outw = (sv > l2) || (sv < ll);
		unique case (mode)
			ccps_pkg::CMP_EVERY: hit = 1'b1;
			ccps_pkg::CMP_LIM_A, ccps_pkg::CMP_LIM_B: hit = (i_legacy || !pol) ? gt1 : lt1;
			ccps_pkg::CMP_WINDOW: hit = i_legacy ? gt2 : (pol ? !outw : outw);
		endcase
		st_next.valid = i_valid;
		st_next.chan = i_chan;
		st_next.result = i_valid ? res : st_reg.result;
		st_next.hit = i_valid && hit;
	end

	// State register
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_valid = st_reg.valid;
	assign o_chan = st_reg.chan;
	assign o_result = st_reg.result;
	assign o_hit = st_reg.hit;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	sequence s_wide_raw;
		i_valid && i_fmt[ccps_pkg::FMT_WIDE_BIT] && (i_fmt[5:3] == 3'h0);
	endsequence
	property p_every;
		i_valid && (i_fmt[1:0] == 2'h0) |=> o_valid && o_hit;
	endproperty
	a_every: assert property (p_every) else $error("mode zero sample gave no event");
	property p_narrow;
		i_valid && !i_fmt[ccps_pkg::FMT_WIDE_BIT] |=> o_result[23:16] == 8'h00;
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow result has upper bits");
	property p_shift;
		i_valid && i_fmt[ccps_pkg::FMT_WIDE_BIT] && (i_fmt[5:3] == 3'h2)
			|=> o_result == {{2{$past(i_acc[23])}}, $past(i_acc[23:2])};
	endproperty
	a_shift: assert property (p_shift) else $error("shift by two wrong");
	property p_below;
		s_wide_raw and (!i_legacy && i_fmt[2:0] == 3'h6 && $signed(i_acc) < $signed(i_first))
			|=> o_hit;
	endproperty
	a_below: assert property (p_below) else $error("below-limit event missed");
	property p_legacy;
		s_wide_raw and (i_legacy && i_fmt[2:0] == 3'h5 && $signed(i_acc) < $signed(i_first))
			|=> !o_hit;
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy honoured polarity");
	property p_window;
		s_wide_raw and (!i_legacy && i_fmt[2:0] == 3'h3 && $signed(i_acc) > $signed(i_second))
			|=> o_hit;
	endproperty
	a_window: assert property (p_window) else $error("window exit missed");
endmodule // ccps_post
`default_nettype wire

/* verilog/ccps_top.sv */
// Six-channel result post-processing and measurement scheduler with AXI4-Lite registers.
// Assumes samples, channel select and bus come from logic on i_mclk.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ccps_top #(
	parameter int P_TICK_CYC = ccps_pkg::TICK_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [11:0] i_s_axi_awaddr,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	output logic [1:0] o_s_axi_bresp,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	input wire logic [11:0] i_s_axi_araddr,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	input wire logic i_sample_valid,
	input wire ccps_pkg::ccps_sample_s i_sample,
	input wire logic [2:0] i_meas_chan,
	output logic [5:0] o_meas_req,
	output logic [5:0] o_force_req,
	output ccps_pkg::ccps_drive_s o_drive,
	output logic o_irq
);
	localparam logic [16:0] TICK_LAST = 17'(P_TICK_CYC - 1);

	ccps_pkg::ccps_top_s st_reg, st_next;
	logic post_valid, post_hit, tick_hit;
	logic [2:0] post_chan;
	logic [23:0] post_result;
	logic samp_ok, rd_hit, wr_hit, wr_go;
	logic [7:0] samp_fmt, ri, wi, drv_cfg;
	logic [31:0] rd_val, wv;
	logic [5:0] sts_clr, sts_set;
	logic [5:0][23:0] per;

	// Byte-lane merge of a write into the old word
	function automatic logic [31:0] mrg(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		mrg = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				mrg[8*b +: 8] = d[8*b +: 8];
			end
		end
	endfunction

	// ----------------------------------------
	// Post-processing of finished samples
	// ----------------------------------------
	// Samples naming a channel past five are dropped
	assign samp_ok = i_sample_valid && (i_sample.chan < 3'd6);
	assign samp_fmt = samp_ok ? st_reg.fmt[i_sample.chan] : ccps_pkg::FMT_RST;

	ccps_post u_ccps_post (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_valid(samp_ok),
		.i_chan(i_sample.chan),
		.i_acc(i_sample.acc),
		.i_fmt(samp_fmt),
		.i_first(st_reg.lim1),
		.i_second(st_reg.lim2),
		.i_low(st_reg.liml),
		.i_legacy(st_reg.legacy),
		.o_valid(post_valid),
		.o_chan(post_chan),
		.o_result(post_result),
		.o_hit(post_hit)
	);

	// ----------------------------------------
	// Per-channel measurement period
	// ----------------------------------------
	for (genvar g = 0; g < ccps_pkg::NCH; g++) begin : g_ch
		logic [1:0] csel;
		logic [7:0] pmsel;
		// Counter select zero picks no multiplier at all
		assign csel = st_reg.sch[g][ccps_pkg::SCH_CNT_LSB +: 2];
		assign pmsel = (csel == 2'h0) ? 8'h00 : st_reg.pm[csel - 2'h1];
		// Zero rate or zero multiplier gives a zero period
		assign per[g] = {8'h00, st_reg.rate} * {16'h0000, pmsel};
	end

	assign tick_hit = (st_reg.tick == TICK_LAST);
	assign wr_go = st_reg.have_aw && st_reg.have_w && !st_reg.bvalid;
	assign wi = st_reg.awaddr[9:2];
	assign ri = i_s_axi_araddr[9:2];
	assign drv_cfg = (i_meas_chan < 3'd6) ? st_reg.sch[i_meas_chan] : ccps_pkg::SCH_RST;

	// ----------------------------------------
	// Register read decode
	// ----------------------------------------
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b0;
		for (int c = 0; c < ccps_pkg::NCH; c++) begin
			if (ri == ccps_pkg::IDX_FMT[c]) begin
				rd_val = {24'h000000, st_reg.fmt[c]};
				rd_hit = 1'b1;
			end
			if (ri == ccps_pkg::IDX_SCH[c]) begin
				rd_val = {24'h000000, st_reg.sch[c]};
				rd_hit = 1'b1;
			end
			if (ri == ccps_pkg::IDX_RES0 + 8'(c)) begin
				rd_val = {8'h00, st_reg.res[c]};
				rd_hit = 1'b1;
			end
		end
		for (int k = 0; k < 3; k++) begin
			if (ri == ccps_pkg::IDX_PM0 + 8'(k)) begin
				rd_val = {24'h000000, st_reg.pm[k]};
				rd_hit = 1'b1;
			end
		end
		if (ri == ccps_pkg::IDX_RATE) begin
			rd_val = {16'h0000, st_reg.rate};
			rd_hit = 1'b1;
		end
		if (ri == ccps_pkg::IDX_LIM1) begin
			rd_val = {8'h00, st_reg.lim1};
			rd_hit = 1'b1;
		end
		if (ri == ccps_pkg::IDX_LIM2) begin
			rd_val = {8'h00, st_reg.lim2};
			rd_hit = 1'b1;
		end
		if (ri == ccps_pkg::IDX_LIML) begin
			rd_val = {8'h00, st_reg.liml};
			rd_hit = 1'b1;
		end
		if (ri == ccps_pkg::IDX_STS) begin
			rd_val = {26'h0000000, st_reg.sts};
			rd_hit = 1'b1;
		end
		if (ri == ccps_pkg::IDX_MSK) begin
			rd_val = {26'h0000000, st_reg.msk};
			rd_hit = 1'b1;
		end
		if (ri == ccps_pkg::IDX_CTL) begin
			rd_val = {31'h00000000, st_reg.legacy};
			rd_hit = 1'b1;
		end
		if (ri == ccps_pkg::IDX_FORCE) begin
			rd_hit = 1'b1;
		end
		// Upper address bits outside the map
		if (i_s_axi_araddr[11:10] != 2'h0) begin
			rd_val = 32'h0000_0000;
			rd_hit = 1'b0;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		wr_hit = 1'b0;
		sts_clr = 6'h00;
		sts_set = 6'h00;
		wv = mrg(32'h0000_0000, st_reg.wdata, st_reg.wstrb);
		st_next.force_req = 6'h00;

		// Write address and data are taken in either order
		if (i_s_axi_awvalid && st_reg.awrdy) begin
			st_next.have_aw = 1'b1;
			st_next.awaddr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && st_reg.wrdy) begin
			st_next.have_w = 1'b1;
			st_next.wdata = i_s_axi_wdata;
			st_next.wstrb = i_s_axi_wstrb;
		end
		if (st_reg.bvalid && i_s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		// Commit a write once both halves are held
		if (wr_go) begin
			for (int c = 0; c < ccps_pkg::NCH; c++) begin
				if (wi == ccps_pkg::IDX_FMT[c]) begin
					st_next.fmt[c] = 8'(mrg({24'h0, st_reg.fmt[c]}, st_reg.wdata, st_reg.wstrb));
					wr_hit = 1'b1;
				end
				if (wi == ccps_pkg::IDX_SCH[c]) begin
					st_next.sch[c] = 8'(mrg({24'h0, st_reg.sch[c]}, st_reg.wdata, st_reg.wstrb));
					wr_hit = 1'b1;
				end
				if (wi == ccps_pkg::IDX_RES0 + 8'(c)) begin
					wr_hit = 1'b1;
				end
			end
			for (int k = 0; k < 3; k++) begin
				if (wi == ccps_pkg::IDX_PM0 + 8'(k)) begin
					st_next.pm[k] = 8'(mrg({24'h0, st_reg.pm[k]}, st_reg.wdata, st_reg.wstrb));
					wr_hit = 1'b1;
				end
			end
			if (wi == ccps_pkg::IDX_RATE) begin
				st_next.rate = 16'(mrg({16'h0, st_reg.rate}, st_reg.wdata, st_reg.wstrb));
				wr_hit = 1'b1;
			end
			if (wi == ccps_pkg::IDX_LIM1) begin
				st_next.lim1 = 24'(mrg({8'h0, st_reg.lim1}, st_reg.wdata, st_reg.wstrb));
				wr_hit = 1'b1;
			end
			if (wi == ccps_pkg::IDX_LIM2) begin
				st_next.lim2 = 24'(mrg({8'h0, st_reg.lim2}, st_reg.wdata, st_reg.wstrb));
				wr_hit = 1'b1;
			end
			if (wi == ccps_pkg::IDX_LIML) begin
				st_next.liml = 24'(mrg({8'h0, st_reg.liml}, st_reg.wdata, st_reg.wstrb));
				wr_hit = 1'b1;
			end
			if (wi == ccps_pkg::IDX_STS) begin
				sts_clr = wv[5:0];
				wr_hit = 1'b1;
			end
			if (wi == ccps_pkg::IDX_MSK) begin
				st_next.msk = 6'(mrg({26'h0, st_reg.msk}, st_reg.wdata, st_reg.wstrb));
				wr_hit = 1'b1;
			end
			if (wi == ccps_pkg::IDX_CTL) begin
				st_next.legacy = wv[ccps_pkg::CTL_LEGACY_BIT];
				wr_hit = 1'b1;
			end
			if (wi == ccps_pkg::IDX_FORCE) begin
				st_next.force_req = wv[5:0];
				wr_hit = 1'b1;
			end
			if (st_reg.awaddr[11:10] != 2'h0) begin
				wr_hit = 1'b0;
			end
			st_next.have_aw = 1'b0;
			st_next.have_w = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = wr_hit ? ccps_pkg::RESP_OK : ccps_pkg::RESP_ERR;
		end
		st_next.awrdy = !st_next.have_aw;
		st_next.wrdy = !st_next.have_w;

		// Reads answer on the same edge that takes the address
		if (st_reg.rvalid && i_s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (i_s_axi_arvalid && st_reg.arrdy) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = rd_val;
			st_next.rresp = rd_hit ? ccps_pkg::RESP_OK : ccps_pkg::RESP_ERR;
		end
		st_next.arrdy = !st_next.rvalid;

		// Store each final result and flag its event
		if (post_valid && (post_chan < 3'd6)) begin
			st_next.res[post_chan] = post_result;
			sts_set[post_chan] = post_hit;
		end
		// An event in the clearing cycle survives
		st_next.sts = (st_reg.sts & ~sts_clr) | sts_set;
		st_next.irq = |(st_next.sts & st_next.msk);

		// Base tick and autonomous period counters
		st_next.tick = tick_hit ? 17'h00000 : st_reg.tick + 17'h00001;
		for (int c = 0; c < ccps_pkg::NCH; c++) begin
			st_next.req[c] = 1'b0;
			if (per[c] == 24'h000000) begin
				st_next.cnt[c] = 24'h000000;
			end else if (tick_hit) begin
				if (st_reg.cnt[c] + 24'h000001 >= per[c]) begin
					st_next.req[c] = 1'b1;
					st_next.cnt[c] = 24'h000000;
				end else begin
					st_next.cnt[c] = st_reg.cnt[c] + 24'h000001;
				end
			end
		end

		// Emitter enables and current bank of the channel being measured
		st_next.drive.on_one = drv_cfg[ccps_pkg::SCH_EM1_BIT];
		st_next.drive.on_two = drv_cfg[ccps_pkg::SCH_EM2_BIT];
		st_next.drive.on_three = drv_cfg[ccps_pkg::SCH_EM3_BIT];
		st_next.drive.bank = drv_cfg[ccps_pkg::SCH_BANK_BIT];
	end

	// State register
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_reg <= '0;
			st_reg.fmt <= {6{ccps_pkg::FMT_RST}};
			st_reg.sch <= {6{ccps_pkg::SCH_RST}};
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_s_axi_awready = st_reg.awrdy;
	assign o_s_axi_wready = st_reg.wrdy;
	assign o_s_axi_bvalid = st_reg.bvalid;
	assign o_s_axi_bresp = st_reg.bresp;
	assign o_s_axi_arready = st_reg.arrdy;
	assign o_s_axi_rvalid = st_reg.rvalid;
	assign o_s_axi_rdata = st_reg.rdata;
	assign o_s_axi_rresp = st_reg.rresp;
	assign o_meas_req = st_reg.req;
	assign o_force_req = st_reg.force_req;
	assign o_drive = st_reg.drive;
	assign o_irq = st_reg.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	sequence s_rate_idle;
		(st_reg.rate == 16'h0000) [*2];
	endsequence
	sequence s_chan0_off;
		(st_reg.sch[0][7:6] == 2'h0) [*2];
	endsequence
	property p_cfg_rst;
		$fell(i_rst) |-> (st_reg.fmt == 48'h0) && (st_reg.sch == 48'h0);
	endproperty
	a_cfg_rst: assert property (p_cfg_rst) else $error("config not zero after reset");
	property p_rate_stop;
		s_rate_idle |-> o_meas_req == 6'h00;
	endproperty
	a_rate_stop: assert property (p_rate_stop) else $error("request with zero rate");
	property p_chan_off;
		s_chan0_off |-> !o_meas_req[0];
	endproperty
	a_chan_off: assert property (p_chan_off) else $error("request with select zero");
	property p_req_tick;
		o_meas_req[0] |-> $past(tick_hit) && (st_reg.cnt[0] == 24'h000000);
	endproperty
	a_req_tick: assert property (p_req_tick) else $error("request off the base tick");
	property p_emit;
		i_meas_chan == 3'h0 |=> o_drive.on_two == $past(st_reg.sch[0][2])
			&& o_drive.on_three == $past(st_reg.sch[0][1])
			&& o_drive.on_one == $past(st_reg.sch[0][0]);
	endproperty
	a_emit: assert property (p_emit) else $error("emitter enable mismatch");
	property p_bank;
		i_meas_chan == 3'h1 |=> o_drive.bank == $past(st_reg.sch[1][3]);
	endproperty
	a_bank: assert property (p_bank) else $error("bank select mismatch");
	property p_post_sts;
		post_valid && post_hit && (post_chan == 3'h2)
			|=> st_reg.sts[2] && (st_reg.res[2] == $past(post_result));
	endproperty
	a_post_sts: assert property (p_post_sts) else $error("event or result not stored");
endmodule // ccps_top
`default_nettype wire

/* sim/ccps_host.sv */
// Host model: AXI4-Lite master with one write task and one read task.
// Assumes a slave on i_mclk; o_hang rises when a wait for an answer runs out.
`timescale 1ns/1ps
`default_nettype none
module ccps_host (
	input wire logic i_mclk,
	output logic o_awvalid,
	output logic [11:0] o_awaddr,
	input wire logic i_awready,
	output logic o_wvalid,
	output logic [31:0] o_wdata,
	output logic [3:0] o_wstrb,
	input wire logic i_wready,
	input wire logic i_bvalid,
	output logic o_bready,
	input wire logic [1:0] i_bresp,
	output logic o_arvalid,
	output logic [11:0] o_araddr,
	input wire logic i_arready,
	input wire logic i_rvalid,
	output logic o_rready,
	input wire logic [31:0] i_rdata,
	input wire logic [1:0] i_rresp,
	output logic o_hang
);
	// Idle bus at time zero
	initial begin
		{o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready, o_hang} = '0;
		{o_awaddr, o_araddr, o_wdata, o_wstrb} = '0;
	end
	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge i_mclk);
		o_awvalid <= 1'b1;
		o_awaddr <= a;
		o_wvalid <= 1'b1;
		o_wdata <= d;
		o_wstrb <= 4'hF;
		o_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge i_mclk);
			if (i_awready) o_awvalid <= 1'b0;
			if (i_wready) o_wvalid <= 1'b0;
			if (i_bvalid) break;
		end
		r = i_bresp;
		o_bready <= 1'b0;
		o_hang <= (n == 100);
	endtask
	// Read: address held until taken, data taken with rvalid
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge i_mclk);
		o_arvalid <= 1'b1;
		o_araddr <= a;
		o_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge i_mclk);
			if (i_arready) o_arvalid <= 1'b0;
			if (i_rvalid) break;
		end
		d = i_rdata;
		r = i_rresp;
		o_rready <= 1'b0;
		o_hang <= (n == 100);
	endtask
endmodule // ccps_host
`default_nettype wire

/* sim/test_channel_result_post_and_schedule.sv */
// Testbench: registers, sample post-processing, compare, schedule, emitter drive.
// Assumes ccps_pkg is compiled first and a short base tick of 8 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) begin \
			fail_count++; \
			$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
		end \
	end
module test_channel_result_post_and_schedule;
	logic i_mclk, i_rst, sv, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, irq, hang, lg;
	logic [11:0] aw, ar;
	logic [31:0] wd, rdt, d;
	logic [3:0] ws;
	logic [1:0] bre, rre, rsp;
	logic [5:0] meas, m, frc;
	logic [7:0] f;
	logic [23:0] l1, l2, lo, a;
	logic [2:0] mch;
	ccps_pkg::ccps_sample_s smp;
	ccps_pkg::ccps_drive_s drv;
	int fail_count = 0;
	int cmp_count = 0;
	int c, n, i, k, r, p;
	ccps_top #(.P_TICK_CYC(8)) u_ccps_top (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(aw),
		.i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
		.o_s_axi_bvalid(bv), .i_s_axi_bready(br), .o_s_axi_bresp(bre),
		.i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ar),
		.o_s_axi_rvalid(rv), .i_s_axi_rready(rr), .o_s_axi_rdata(rdt), .o_s_axi_rresp(rre),
		.i_sample_valid(sv), .i_sample(smp), .i_meas_chan(mch), .o_meas_req(meas),
		.o_force_req(frc), .o_drive(drv), .o_irq(irq));
	ccps_host u_host (.i_mclk(i_mclk), .o_awvalid(awv), .o_awaddr(aw), .i_awready(awr),
		.o_wvalid(wv), .o_wdata(wd), .o_wstrb(ws), .i_wready(wrd), .i_bvalid(bv),
		.o_bready(br), .i_bresp(bre), .o_arvalid(arv), .o_araddr(ar), .i_arready(arr),
		.i_rvalid(rv), .o_rready(rr), .i_rdata(rdt), .i_rresp(rre), .o_hang(hang));
	// ----------------------------------------
	// Clock, verdict and hang guards
	// ----------------------------------------
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end
	task automatic end_of_test;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge i_mclk);
		fail_count++;
		end_of_test();
	end
	always @(posedge hang) begin
		fail_count++;
		end_of_test();
	end
	// ----------------------------------------
	// Bus helpers and expectation functions
	// ----------------------------------------
	task automatic wr(input logic [7:0] x, input logic [31:0] v);
		u_host.wr({2'b00, x, 2'b00}, v, rsp);
	endtask
	task automatic chk(input logic [7:0] x, input logic [31:0] e, input logic [1:0] er);
		u_host.rd({2'b00, x, 2'b00}, d, rsp);
		`CHK(d, e)
		`CHK(rsp, er)
	endtask
	function automatic int cv(logic [23:0] x, logic w);
		return w ? int'($signed(x)) : int'(x[15:0]);
	endfunction
	function automatic logic [23:0] post(logic [23:0] x, logic [7:0] g);
		logic [23:0] s;
		s = 24'($signed(x) >>> g[5:3]);
		return g[6] ? s : {8'h00, s[15:0]};
	endfunction
	function automatic logic hit(logic [23:0] x, logic [7:0] g, logic old);
		int v;
		v = cv(x, g[6]);
		if (g[1:0] == 2'h0) return 1'b1;
		if (g[1:0] != 2'h3) return old ? v > cv(l1, g[6]) : (g[2] ? v < cv(l1, g[6]) : v > cv(l1, g[6]));
		if (old) return v > cv(l2, g[6]);
		return g[2] == (v >= cv(lo, g[6]) && v <= cv(l2, g[6]));
	endfunction
	// Wait for one request pulse of a channel, then count cycles to the next
	task automatic gap(input int ch, output int cnt);
		for (cnt = 0; cnt < 400 && !meas[ch]; cnt++) @(posedge i_mclk);
		cnt = 0;
		do begin
			@(posedge i_mclk);
			cnt++;
		end while (cnt < 400 && !meas[ch]);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		i_rst = 1'b1;
		sv = 1'b0;
		smp = '0;
		mch = 3'h0;
		void'($urandom(32'hE32E));
		repeat (10) @(posedge i_mclk);
		i_rst <= 1'b0;
		// Reset values, then random write and read back
		for (c = 0; c < 6; c++) begin
			chk(ccps_pkg::IDX_FMT[c], 32'h0, ccps_pkg::RESP_OK);
			chk(ccps_pkg::IDX_SCH[c], 32'h0, ccps_pkg::RESP_OK);
			f = 8'($urandom) & 8'h7F;
			wr(ccps_pkg::IDX_FMT[c], 32'(f));
			chk(ccps_pkg::IDX_FMT[c], 32'(f), ccps_pkg::RESP_OK);
			f = 8'($urandom);
			wr(ccps_pkg::IDX_SCH[c], 32'(f));
			chk(ccps_pkg::IDX_SCH[c], 32'(f), ccps_pkg::RESP_OK);
		end
		chk(8'hFF, 32'h0, ccps_pkg::RESP_ERR);
		// Random samples through shift, width and every compare mode
		for (i = 0; i < 48; i++) begin
			c = $urandom % 6;
			f = 8'($urandom) & 8'h7F;
			lg = 1'($urandom % 4 == 0);
			m = 6'($urandom);
			l1 = 24'($urandom);
			l2 = 24'($urandom);
			lo = 24'($urandom);
			a = 24'($urandom);
			// Corner cases first: below limit, legacy ignores polarity, window exit
			if (i < 3) begin
				f = (i == 0) ? 8'h46 : (i == 1) ? 8'h45 : 8'h43;
				lg = (i == 1);
				a = 24'h000010;
				l1 = 24'h000100;
				l2 = 24'h000008;
			end
			wr(ccps_pkg::IDX_FMT[c], 32'(f));
			wr(ccps_pkg::IDX_LIM1, 32'(l1));
			wr(ccps_pkg::IDX_LIM2, 32'(l2));
			wr(ccps_pkg::IDX_LIML, 32'(lo));
			wr(ccps_pkg::IDX_CTL, 32'(lg));
			wr(ccps_pkg::IDX_MSK, 32'(m));
			@(posedge i_mclk);
			sv <= 1'b1;
			smp <= '{chan: 3'(c), acc: a};
			@(posedge i_mclk);
			sv <= 1'b0;
			repeat (2) @(posedge i_mclk);
			#1;
			`CHK(irq, hit(post(a, f), f, lg) & m[c])
			chk(ccps_pkg::IDX_RES0 + 8'(c), 32'(post(a, f)), ccps_pkg::RESP_OK);
			chk(ccps_pkg::IDX_STS, 32'(hit(post(a, f), f, lg)) << c, ccps_pkg::RESP_OK);
			wr(ccps_pkg::IDX_STS, 32'h3F);
			`CHK(irq, 1'b0)
		end
		// Autonomous period, then each way of stopping it
		for (k = 0; k < 3; k++) begin
			// Channel zero first so its request checks see traffic
			c = (k == 0) ? 0 : $urandom % 6;
			r = 1 + $urandom % 2;
			p = 1 + $urandom % 3;
			wr(ccps_pkg::IDX_RATE, 32'(r));
			wr(ccps_pkg::IDX_PM0 + 8'(k), 32'(p));
			wr(ccps_pkg::IDX_SCH[c], 32'(k + 1) << 6);
			gap(c, n);
			`CHK(n, r * p * 8)
			wr(ccps_pkg::IDX_PM0 + 8'(k), 32'h0);
			gap(c, n);
			`CHK(n, 400)
			wr(ccps_pkg::IDX_PM0 + 8'(k), 32'(p));
			wr(ccps_pkg::IDX_RATE, 32'h0);
			gap(c, n);
			`CHK(n, 400)
			wr(ccps_pkg::IDX_RATE, 32'(r));
			wr(ccps_pkg::IDX_SCH[c], 32'h0);
			gap(c, n);
			`CHK(n, 400)
		end
		// Emitter enables and bank follow the channel being measured
		for (c = 0; c < 7; c++) begin
			f = 8'($urandom);
			if (c < 6) wr(ccps_pkg::IDX_SCH[c], 32'(f));
			@(posedge i_mclk);
			mch <= 3'(c);
			repeat (2) @(posedge i_mclk);
			#1;
			`CHK(drv, (c < 6) ? {f[0], f[2], f[1], f[3]} : 4'h0)
		end
		// Force register pulses its channels for one cycle and reads back zero
		f = (8'($urandom) & 8'h3F) | 8'h01;
		wr(ccps_pkg::IDX_FORCE, 32'(f));
		`CHK(frc, f[5:0])
		@(posedge i_mclk);
		#1;
		`CHK(frc, 6'h00)
		chk(ccps_pkg::IDX_FORCE, 32'h0, ccps_pkg::RESP_OK);
		end_of_test();
	end
endmodule // test_channel_result_post_and_schedule
`default_nettype wire
